// [pdw_watchdog.v]
// Process data watchdog, connection monitor, fail-safe outputs and special registers
`timescale 1ns/100ps
`default_nettype none
`include "pdw_map.vh"
module pdw_watchdog #(
    parameter MS_CYCLES = `PDW_MS_CYCLES  // Clock cycles per millisecond tick
) (
    input  wire        clk_sys,
    input  wire        sys_rst,
    input  wire        req_valid,
    input  wire        req_write,
    input  wire [7:0]  req_fc,
    input  wire [2:0]  req_conn,
    input  wire [15:0] req_addr,
    input  wire [15:0] req_wdata,
    input  wire [15:0] req_wmask,
    output reg         rsp_valid,
    output reg  [15:0] rsp_rdata,
    output reg  [7:0]  rsp_exc,
    input  wire        ack_manual,
    input  wire        data_interface_timeout,
    input  wire        host_timeout,
    input  wire        conn_aborted,
    input  wire        init_error,
    input  wire [15:0] diag_flags,
    input  wire [15:0] diag_location,
    input  wire [7:0]  din,
    output reg  [7:0]  dout,
    output wire        network_indicator
);

    // Pin input synchroniser; first stage is read only by the second
    reg  [7:0]  din_s1_q;
    reg  [7:0]  din_s2_q;

    // Register file
    reg  [15:0] wd_to_q;           // Watchdog timeout in ms
    reg  [15:0] conn_to_q;         // Connection monitor timeout in ms
    reg  [15:0] fault_sel_q;       // Substitute behaviour select
    reg  [15:0] reason_q;          // Last failure reason
    reg  [15:0] out_image_q;       // Latest written output data
    reg  [7:0]  held_q;            // Outputs frozen at failure entry

    // Watchdog state
    reg         wd_run_q;          // Started by first output write
    reg  [15:0] wd_cnt_q;          // Elapsed ms since last trigger
    reg         fail_q;            // Network failure state
    reg  [31:0] tick_cnt_q;        // Divider for the ms tick
    reg         tick_q;            // One-cycle ms tick

    // Request decode
    reg  [7:0]  exc;               // Exception for the current request
    reg  [15:0] rdata;             // Read data for the current request
    wire        is_bit_fc;         // Coil or discrete access
    wire        fc_ok;             // Supported function code
    wire        hit_out;           // Output image addressed
    wire        acc_ok;            // Request accepted without exception
    wire        do_wr;             // Accepted write
    wire        cmd_wr;            // Accepted command write
    wire        one_hot;           // Exactly one command bit set
    wire        trig;              // Watchdog trigger
    wire        ack_cmd;           // Manual acknowledge command
    wire        user_set;          // Set-failure command
    wire        wd_expire;         // Watchdog timeout reached
    wire        mb_expire;         // Any connection monitor timed out
    wire        any_set;           // Any failure source this cycle
    wire        clr;               // Failure clear this cycle
    wire [`PDW_NCONN-1:0] conn_exp; // Per-connection expiry

    // Bit functions may only reach the two process data images
    assign is_bit_fc = (req_fc == 8'h01) || (req_fc == 8'h02) || (req_fc == 8'h05) || (req_fc == 8'h0F);
    // Only the listed function codes are served
    assign fc_ok = is_bit_fc || (req_fc == 8'h03) || (req_fc == 8'h04) || (req_fc == 8'h06)
                   || (req_fc == 8'h10) || (req_fc == 8'h17);
    assign hit_out  = (req_addr == `PDW_ADR_OUT_IMAGE);
    // Power-of-two test: a command word must carry exactly one bit
    assign one_hot  = (req_wdata != 16'h0000) && ((req_wdata & (req_wdata - 16'h0001)) == 16'h0000);
    // A refused request writes no register and feeds no timer but its connection monitor
    assign acc_ok   = req_valid && (exc == `PDW_EXC_NONE);
    assign do_wr    = acc_ok && req_write;
    assign cmd_wr   = do_wr && (req_addr == `PDW_ADR_CMD);
    // Only accepted writes to the output image feed the watchdog
    assign trig     = do_wr && hit_out;
    assign ack_cmd  = cmd_wr && req_wdata[`PDW_CMD_ACK_FAIL];
    assign user_set = cmd_wr && req_wdata[`PDW_CMD_SET_FAIL];

    // Access check and read mux
    always @* begin
        exc   = `PDW_EXC_NONE;
        rdata = 16'h0000;
        if (!fc_ok) begin
            exc = `PDW_EXC_FUNC;
        end else if (is_bit_fc && !hit_out && (req_addr != `PDW_ADR_IN_IMAGE)) begin
            exc = `PDW_EXC_ADDR;
        end else begin
            case (req_addr)
                `PDW_ADR_CONN_TO:   rdata = conn_to_q;
                `PDW_ADR_WD_TO:     rdata = wd_to_q;
                `PDW_ADR_FAULT_SEL: rdata = fault_sel_q;
                `PDW_ADR_OUT_IMAGE: rdata = out_image_q;
                `PDW_ADR_REASON:    rdata = reason_q;
                `PDW_ADR_STATUS: begin
                    rdata[`PDW_ST_ERROR]   = (diag_flags != 16'h0000);
                    rdata[`PDW_ST_NETFAIL] = fail_q;
                end
                `PDW_ADR_DIAG_FLAGS: rdata = diag_flags;
                `PDW_ADR_DIAG_LOC:   rdata = diag_location;
                `PDW_ADR_IN_IMAGE:   rdata = {8'h00, din_s2_q};
                `PDW_ADR_CMD: begin
                    // Write-only; a read is refused
                    if (!req_write) begin
                        exc = `PDW_EXC_ADDR;
                    end else if (!one_hot) begin
                        exc = `PDW_EXC_VALUE;
                    end
                end
                default: exc = `PDW_EXC_ADDR;
            endcase
            // Read-only registers refuse writes and keep their value
            if (req_write && ((req_addr == `PDW_ADR_REASON) || (req_addr == `PDW_ADR_STATUS)
                || (req_addr == `PDW_ADR_DIAG_FLAGS) || (req_addr == `PDW_ADR_DIAG_LOC)
                || (req_addr == `PDW_ADR_IN_IMAGE))) begin
                exc = `PDW_EXC_ADDR;
            end
        end
    end

    // Answer one cycle after the request
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            rsp_valid <= 1'b0;
            rsp_rdata <= 16'h0000;
            rsp_exc   <= 8'h00;
        end else begin
            rsp_valid <= req_valid;
            // Zeroed on writes and refusals so no stale word leaks out
            rsp_rdata <= (req_valid && !req_write && (exc == `PDW_EXC_NONE)) ? rdata : 16'h0000;
            rsp_exc   <= req_valid ? exc : 8'h00;
        end
    end

    // Pin synchroniser
    // Inputs are only read as levels, so two flops suffice and no edge is needed
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            din_s1_q <= 8'h00;
            din_s2_q <= 8'h00;
        end else begin
            din_s1_q <= din;
            din_s2_q <= din_s1_q;
        end
    end

    // Register writes; output data is stored even during a failure
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            wd_to_q     <= `PDW_RST_WD_TO;
            conn_to_q   <= `PDW_RST_CONN_TO;
            fault_sel_q <= `PDW_RST_FAULT_SEL;
            out_image_q <= 16'h0000;
        end else if (do_wr) begin
            case (req_addr)
                `PDW_ADR_WD_TO:     wd_to_q     <= req_wdata;
                `PDW_ADR_CONN_TO:   conn_to_q   <= req_wdata;
                `PDW_ADR_FAULT_SEL: fault_sel_q <= req_wdata;
                `PDW_ADR_OUT_IMAGE: out_image_q <= (out_image_q & ~req_wmask)
                                                   | (req_wdata & req_wmask);
                // Command and refused addresses store nothing
                default: ;
            endcase
        end
    end

    // Millisecond tick divider
    // A 32-bit divider covers any clock rate; simulation shortens the period
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            tick_cnt_q <= 32'h0000_0000;
            tick_q     <= 1'b0;
        end else if (tick_cnt_q == MS_CYCLES - 1) begin
            tick_cnt_q <= 32'h0000_0000;
            tick_q     <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
            tick_q     <= 1'b0;
        end
    end

    // A zero timeout never expires; counting stops while failed
    assign wd_expire = wd_run_q && !fail_q && (wd_to_q != 16'h0000) && (wd_cnt_q >= wd_to_q);

    // Counts saturate at all ones so a late timeout never wraps back to zero
    // Watchdog counter; the run flag has no clear path once set
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            wd_run_q <= 1'b0;
            wd_cnt_q <= 16'h0000;
        end else begin
            // A zero timeout leaves the watchdog asleep until a real value arrives
            if (trig && (wd_to_q != 16'h0000)) begin
                wd_run_q <= 1'b1;
            end
            if (trig || clr || fail_q) begin
                wd_cnt_q <= 16'h0000;
            end else if (wd_run_q && tick_q && (wd_cnt_q != 16'hFFFF)) begin
                wd_cnt_q <= wd_cnt_q + 16'h0001;
            end
        end
    end

    // Per-connection monitors, each with its own latched timeout
    genvar gi;
    generate
        for (gi = 0; gi < `PDW_NCONN; gi = gi + 1) begin : g_conn
            reg  [15:0] act_to_q;  // Timeout in force on this connection
            reg  [15:0] cnt_q;     // Elapsed ms since last function
            reg         live_q;    // Connection has executed a function
            wire        hit;       // Function executed on this connection
            // A refused request still counts as activity on its connection
            assign hit = req_valid && (req_conn == gi);
            assign conn_exp[gi] = live_q && (act_to_q != 16'h0000) && (cnt_q >= act_to_q);
            always @(posedge clk_sys or posedge sys_rst) begin
                if (sys_rst) begin
                    act_to_q <= `PDW_RST_CONN_TO;
                    cnt_q    <= 16'h0000;
                    live_q   <= 1'b0;
                end else if (hit) begin
                    act_to_q <= conn_to_q;
                    cnt_q    <= 16'h0000;
                    live_q   <= 1'b1;
                end else if (conn_exp[gi]) begin
                    // Report once, then wait for the client to come back
                    live_q <= 1'b0;
                end else if (live_q && tick_q && (cnt_q != 16'hFFFF)) begin
                    cnt_q <= cnt_q + 16'h0001;
                end
            end
        end
    endgenerate

    // Every failure source funnels into the one flag and the one reason
    assign mb_expire = |conn_exp;
    assign any_set = wd_expire || mb_expire || user_set || data_interface_timeout
                     || host_timeout || conn_aborted || init_error;
    // Auto mode clears on a valid output write, manual on the command
    assign clr = fail_q && (ack_manual ? ack_cmd : trig);

    // Failure state and reason; a new failure wins over a clear
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            fail_q   <= 1'b0;
            reason_q <= `PDW_RST_REASON;
        end else begin
            if (any_set) begin
                fail_q <= 1'b1;
            end else if (clr) begin
                fail_q <= 1'b0;
            end
            // Priority only matters when two sources fire in one cycle
            // The reason survives a clear so the client can still read it
            if (wd_expire) begin
                reason_q <= `PDW_RSN_WDOG;
            end else if (mb_expire) begin
                reason_q <= `PDW_RSN_MODBUS;
            end else if (user_set) begin
                reason_q <= `PDW_RSN_USER;
            end else if (data_interface_timeout) begin
                reason_q <= `PDW_RSN_DTI;
            end else if (host_timeout) begin
                reason_q <= `PDW_RSN_HOST;
            end else if (conn_aborted) begin
                reason_q <= `PDW_RSN_ABORT;
            end else if (init_error) begin
                reason_q <= `PDW_RSN_INIT;
            end
        end
    end

    // Output drive; hold mode freezes the values seen at failure entry
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            held_q <= 8'h00;
            dout   <= 8'h00;
        end else begin
            if (!fail_q) begin
                held_q <= out_image_q[7:0];
            end
            if (!fail_q) begin
                dout <= out_image_q[7:0];
            end else begin
                case (fault_sel_q)
                    `PDW_FR_HIGH: dout <= 8'hFF;
                    `PDW_FR_HOLD: dout <= held_q;
                    // Unknown codes fall back to all outputs low, the safe state
                    default:      dout <= 8'h00;
                endcase
            end
        end
    end

    // Driven by the flag itself, so it cannot disagree with status bit 1
    assign network_indicator = fail_q;

endmodule // pdw_watchdog
`default_nettype wire

// [pdw_map.vh]
// Register map, field positions, reset values and timing constants of the watchdog block
//
// Behaviour
// - Timeout resets to zero: watchdog disabled
// - First output write starts, later writes restart
// - Reads never trigger the watchdog
// - Expiry drives outputs to substitute behaviour
// - Expiry sets fail flag, status bit 1
// - Running watchdog cannot be stopped by client; here a client write of zero to the timeout still disables expiry
// - Substitute outputs held until failure acknowledged
// - Acknowledge restarts watchdog count
// - Auto mode: output write clears failure
// - Manual mode: acknowledge command clears failure
// - Fault response: low, high, hold last
// - Eight connections served concurrently
// - Supported function codes 1-6,15,16,23
// - Write to read-only: unchanged, exception 02
// - Connection timeout in ms, zero disables
// - New connection timeout applies after function
// - Failure reason codes 0007 to 000D
// - Special register access rights as listed
// - Either timeout expiry enters failure state
// - Output writes accepted during failure, applied after
// - Command needs exactly one bit set
`ifndef PDW_MAP_VH
`define PDW_MAP_VH
// Register word numbers
`define PDW_ADR_CONN_TO    16'h0500
`define PDW_ADR_WD_TO      16'h07D0
`define PDW_ADR_FAULT_SEL  16'h07D2
`define PDW_ADR_REASON     16'h07D4
`define PDW_ADR_CMD        16'h07D6
`define PDW_ADR_STATUS     16'h1F3C
`define PDW_ADR_DIAG_FLAGS 16'h1F3D
`define PDW_ADR_DIAG_LOC   16'h1F3E
`define PDW_ADR_IN_IMAGE   16'h1F40
`define PDW_ADR_OUT_IMAGE  16'h2328
// Reset values
`define PDW_RST_WD_TO      16'h0000
`define PDW_RST_CONN_TO    16'h0000
`define PDW_RST_FAULT_SEL  16'h0000
`define PDW_RST_REASON     16'h0000
// Fault response codes
`define PDW_FR_LOW         16'h0000
`define PDW_FR_HIGH        16'h0001
`define PDW_FR_HOLD        16'h0002
// Failure reason codes
`define PDW_RSN_DTI        16'h0007
`define PDW_RSN_HOST       16'h0008
`define PDW_RSN_USER       16'h0009
`define PDW_RSN_ABORT      16'h000A
`define PDW_RSN_INIT       16'h000B
`define PDW_RSN_WDOG       16'h000C
`define PDW_RSN_MODBUS     16'h000D
// Command and status bit positions
`define PDW_CMD_SET_FAIL   4
`define PDW_CMD_ACK_FAIL   5
`define PDW_ST_ERROR       0
`define PDW_ST_NETFAIL     1
// Modbus exception codes
`define PDW_EXC_NONE       8'h00
`define PDW_EXC_FUNC       8'h01
`define PDW_EXC_ADDR       8'h02
`define PDW_EXC_VALUE      8'h03
// Timing: clock rate and millisecond tick; number of connections
`define PDW_CLK_KHZ        100000
`define PDW_TICK_MS        1
`define PDW_MS_CYCLES      (`PDW_CLK_KHZ * `PDW_TICK_MS)
`define PDW_NCONN          8
`endif

// [pdw_client.sv]
// Client model that issues single-word register accesses to the watchdog block
`timescale 1ns/100ps
`default_nettype none
module pdw_client (
    input  wire logic        clk_sys,
    output var  logic        req_valid,
    output var  logic        req_write,
    output var  logic [7:0]  req_fc,
    output var  logic [2:0]  req_conn,
    output var  logic [15:0] req_addr,
    output var  logic [15:0] req_wdata,
    output var  logic [15:0] req_wmask,
    input  wire logic        rsp_valid,
    input  wire logic [15:0] rsp_rdata,
    input  wire logic [7:0]  rsp_exc
);
    // Idle port at time zero; traffic goes out on connection 0 until use_conn changes it
    initial begin
        req_valid = 1'b0;
        req_write = 1'b0;
        req_fc    = 8'h03;
        req_conn  = 3'h0;
        req_addr  = 16'h0000;
        req_wdata = 16'h0000;
        req_wmask = 16'hffff;
    end
    // Later accesses go out on another connection, changed at a clock edge
    task automatic use_conn(input logic [2:0] c);
        @(posedge clk_sys);
        req_conn <= c;
    endtask
    // One pulse carries one word; the answer is taken one cycle later
    task automatic acc(input logic w, input logic [7:0] fc, input logic [15:0] a,
                       input logic [15:0] d, output logic [15:0] rd, output logic [7:0] ex);
        @(posedge clk_sys);
        req_valid <= 1'b1;
        req_write <= w;
        req_fc    <= fc;
        req_addr  <= a;
        req_wdata <= d;
        req_wmask <= (fc == 8'h05) ? 16'h0001 : 16'hffff;
        @(posedge clk_sys);
        req_valid <= 1'b0;
        // Released fields must not keep showing the last value
        req_addr  <= ~a;
        req_wdata <= ~d;
        #1;
        rd = rsp_rdata;
        // A missing answer shows as an impossible code
        ex = rsp_valid ? rsp_exc : 8'hee;
    endtask
endmodule // pdw_client
`default_nettype wire

// [pdw_watchdog_monitor.sv]
// Concurrent checks on the register port and the fail-safe outputs
`timescale 1ns/100ps
`default_nettype none
`include "pdw_map.vh"
module pdw_watchdog_monitor (
    input wire logic        clk_sys,
    input wire logic        sys_rst,
    input wire logic        req_valid,
    input wire logic        req_write,
    input wire logic [7:0]  req_fc,
    input wire logic [15:0] req_addr,
    input wire logic [15:0] req_wdata,
    input wire logic        rsp_valid,
    input wire logic [15:0] rsp_rdata,
    input wire logic [7:0]  rsp_exc,
    input wire logic        ack_manual,
    input wire logic [7:0]  dout,
    input wire logic        network_indicator
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);
    wire fc_ok = req_fc inside {8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0f, 8'h10, 8'h17};
    wire wr6   = req_valid & req_write & (req_fc == 8'h06);  // Single word writes
    wire multi = (req_wdata & (req_wdata - 16'h0001)) != 16'h0000;
    // Accepted writes that may end a failure, depending on the mode
    wire clr   = req_valid & req_write & fc_ok & ((req_addr == `PDW_ADR_OUT_IMAGE & !ack_manual)
                 | (req_addr == `PDW_ADR_CMD & req_wdata == 16'h0020));
    property p_rsp_next;
        req_valid |=> rsp_valid;
    endproperty
    a_rsp_next: assert property (p_rsp_next) else $error("no answer after a request");
    property p_rsp_idle;
        !req_valid |=> !rsp_valid;
    endproperty
    a_rsp_idle: assert property (p_rsp_idle) else $error("answer without request");
    property p_bad_fc;
        req_valid && !fc_ok |=> rsp_exc == 8'h01;
    endproperty
    a_bad_fc: assert property (p_bad_fc) else $error("unsupported function accepted");
    property p_ro_wr;
        wr6 && req_addr == `PDW_ADR_REASON |=> rsp_exc == 8'h02;
    endproperty
    a_ro_wr: assert property (p_ro_wr) else $error("read-only write not refused");
    property p_cmd_multi;
        wr6 && req_addr == `PDW_ADR_CMD && multi |=> rsp_exc == 8'h03;
    endproperty
    a_cmd_multi: assert property (p_cmd_multi) else $error("multi-bit command accepted");
    property p_status;
        req_valid && !req_write && req_fc == 8'h03 && req_addr == `PDW_ADR_STATUS
            |=> rsp_rdata[1] == $past(network_indicator);
    endproperty
    a_status: assert property (p_status) else $error("status bit 1 differs from indicator");
    property p_hold;
        network_indicator && $past(network_indicator) && $past(network_indicator, 2) |-> $stable(dout);
    endproperty
    a_hold: assert property (p_hold) else $error("outputs moved during failure");
    property p_clear_cause;
        $fell(network_indicator) |-> $past(clr) || $past(clr, 2);
    endproperty
    a_clear_cause: assert property (p_clear_cause) else $error("failure ended without acknowledge");
    property p_dout_pass;
        wr6 && req_addr == `PDW_ADR_OUT_IMAGE && !network_indicator
            |=> ##1 network_indicator || {8'h00, dout} == ($past(req_wdata, 2) & 16'h00ff);
    endproperty
    a_dout_pass: assert property (p_dout_pass) else $error("output image not on outputs");
endmodule // pdw_watchdog_monitor
bind pdw_watchdog pdw_watchdog_monitor pdw_watchdog_monitor_i (.clk_sys, .sys_rst, .req_valid,
    .req_write, .req_fc, .req_addr, .req_wdata, .rsp_valid, .rsp_rdata, .rsp_exc, .ack_manual,
    .dout, .network_indicator);
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the process data watchdog block
`timescale 1ns/100ps
`default_nettype none
`include "pdw_map.vh"
module tb_top;
    localparam int MS = 10;  // Short tick keeps 200 ms at 2000 cycles
    logic        clk_sys, sys_rst, ack_manual, req_valid, req_write, rsp_valid, network_indicator;
    logic [3:0]  flt;        // Interface, host, abort, init failure pulses
    logic [7:0]  din, dout, req_fc, rsp_exc, ex;
    logic [2:0]  req_conn;
    logic [15:0] req_addr, req_wdata, req_wmask, rsp_rdata, rd;
    int          err_count, n_checks;
    logic [7:0]  fcs [9] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0f, 8'h10, 8'h17};
    logic [7:0]  subs [3] = '{8'h00, 8'hff, 8'h5a};  // Low, high, hold last
    logic [15:0] rsn [4] = '{16'h0007, 16'h0008, 16'h000a, 16'h000b};
    pdw_watchdog #(.MS_CYCLES(MS)) pdw_watchdog_i (.clk_sys, .sys_rst, .req_valid, .req_write,
        .req_fc, .req_conn, .req_addr, .req_wdata, .req_wmask, .rsp_valid, .rsp_rdata, .rsp_exc,
        .ack_manual, .data_interface_timeout(flt[0]), .host_timeout(flt[1]), .conn_aborted(flt[2]),
        .init_error(flt[3]), .diag_flags(16'h0000), .diag_location(16'h0000), .din, .dout,
        .network_indicator);
    pdw_client pdw_client_i (.clk_sys, .req_valid, .req_write, .req_fc, .req_conn, .req_addr,
        .req_wdata, .req_wmask, .rsp_valid, .rsp_rdata, .rsp_exc);
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_of_test;
        if (err_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        pdw_client_i.acc(1'b1, 8'h06, a, d, rd, ex);
    endtask
    task automatic rdv(input logic [15:0] a);
        pdw_client_i.acc(1'b0, 8'h03, a, 16'h0000, rd, ex);
    endtask
    // Status reads only, so nothing here may feed the watchdog
    task automatic polls(input int n);
        repeat (n) rdv(`PDW_ADR_STATUS);
    endtask
    task automatic nf(input logic e);
        rdv(`PDW_ADR_STATUS);
        chk("status", rd & 16'h0002, {14'h0000, e, 1'b0});
        chk("indicator", {15'h0000, network_indicator}, {15'h0000, e});
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // Tests need about 20000 cycles; 50000 cycles means a hang
    initial begin
        #500000;
        err_count++;
        end_of_test();
    end
    initial begin
        sys_rst = 1'b1;
        ack_manual = 1'b0;
        flt = 4'h0;
        din = 8'h96;
        err_count = 0;
        n_checks = 0;
        repeat (16) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rdv(`PDW_ADR_WD_TO);
        chk("wd timeout", rd, 16'h0000);
        rdv(`PDW_ADR_IN_IMAGE);
        chk("inputs", rd, 16'h0096);
        foreach (fcs[i]) begin
            pdw_client_i.acc(fcs[i] inside {8'h05, 8'h06, 8'h0f, 8'h10}, fcs[i], `PDW_ADR_OUT_IMAGE, 16'h0000, rd, ex);
            chk("exception", {8'h00, ex}, 16'h0000);
        end
        pdw_client_i.acc(1'b0, 8'h07, `PDW_ADR_OUT_IMAGE, 16'h0000, rd, ex);
        chk("exception", {8'h00, ex}, 16'h0001);
        wr(`PDW_ADR_REASON, 16'h1234);
        chk("exception", {8'h00, ex}, 16'h0002);
        rdv(`PDW_ADR_REASON);
        chk("reason", rd, 16'h0000);
        rdv(`PDW_ADR_CMD);
        chk("exception", {8'h00, ex}, 16'h0002);
        wr(`PDW_ADR_CMD, 16'h0030);
        chk("exception", {8'h00, ex}, 16'h0003);
        nf(1'b0);
        // A zero timeout never expires
        wr(`PDW_ADR_OUT_IMAGE, 16'h0055);
        polls(1100);
        nf(1'b0);
        chk("outputs", {8'h00, dout}, 16'h0055);
        wr(`PDW_ADR_WD_TO, 16'h00c8);
        for (int k = 0; k < 3; k++) begin
            wr(`PDW_ADR_FAULT_SEL, 16'(k));
            wr(`PDW_ADR_OUT_IMAGE, 16'h005a);
            polls(1100);
            nf(1'b1);
            rdv(`PDW_ADR_REASON);
            chk("reason", rd, 16'h000c);
            chk("outputs", {8'h00, dout}, {8'h00, subs[k]});
            wr(`PDW_ADR_OUT_IMAGE, 16'h003c);
            nf(1'b0);
            chk("outputs", {8'h00, dout}, 16'h003c);
        end
        // Writes inside the timeout keep the watchdog quiet
        repeat (3) begin
            polls(700);
            wr(`PDW_ADR_OUT_IMAGE, 16'h0011);
        end
        nf(1'b0);
        @(posedge clk_sys);
        ack_manual <= 1'b1;
        polls(1100);
        nf(1'b1);
        wr(`PDW_ADR_OUT_IMAGE, 16'h00c3);
        nf(1'b1);
        chk("outputs", {8'h00, dout}, 16'h0011);
        wr(`PDW_ADR_CMD, 16'h0020);
        nf(1'b0);
        chk("outputs", {8'h00, dout}, 16'h00c3);
        polls(1100);
        nf(1'b1);
        wr(`PDW_ADR_WD_TO, 16'h0000);
        wr(`PDW_ADR_CMD, 16'h0020);
        wr(`PDW_ADR_CMD, 16'h0010);
        rdv(`PDW_ADR_REASON);
        chk("reason", rd, 16'h0009);
        wr(`PDW_ADR_CMD, 16'h0020);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_sys);
            flt <= 4'h1 << i;
            @(posedge clk_sys);
            flt <= 4'h0;
            rdv(`PDW_ADR_REASON);
            chk("reason", rd, rsn[i]);
            wr(`PDW_ADR_CMD, 16'h0020);
        end
        // Connection monitor takes the new value at the next request
        wr(`PDW_ADR_CONN_TO, 16'h00c8);
        rdv(`PDW_ADR_CONN_TO);
        chk("conn timeout", rd, 16'h00c8);
        // Busy traffic on another connection must not keep connection 0 alive
        pdw_client_i.use_conn(3'h1);
        polls(1100);
        nf(1'b1);
        rdv(`PDW_ADR_REASON);
        chk("reason", rd, 16'h000d);
        end_of_test();
    end
endmodule // tb_top
`default_nettype wire
